// ==== design/scr_readback_top.sv ====
`timescale 1ns/10ps
// Overview of operation
// RULE_01 - readback word is 24 bits; its two top type bits read zero
// RULE_02 - bits 21 to 18 show clamp enables of channels 3 to 0
// RULE_03 - clamp enable reads the latest write from system or channel register
// RULE_04 - bits 17 to 14 show comparator output enables of channels 3 to 0
// RULE_05 - comparator output enable reads the latest write from either register
// RULE_06 - bit 13 shows the global comparator enable
// RULE_07 - bit 12 is one for per-channel ground sense, zero for guard inputs
// RULE_08 - bits 11 and 10 show guard and clamp fault routing to the pin
// RULE_09 - bit 9 shows whether the internal link resistors are connected
// RULE_10 - bit 8 shows the guard amplifier enable
// RULE_11 - bits 7 and 6 return the measure output range as written
// RULE_12 - bit 5 thermal cutoff enable, bits 4 and 3 thermal limit
// RULE_13 - bit 2 is one when fault outputs are latched
// RULE_14 - bits 1 and 0 always read zero
// RULE_15 - host first sends a readback command choosing the register
// RULE_16 - after readback, word sits in top 24 of 29 bits, five zeros below
// RULE_17 - host shifts at least 24 edges; a 24-bit frame must be a no-op
// RULE_18 - word is captured when the readback command completes
module scr_readback_top
   import scr_pkg::*;
#(
   parameter int CHANNELS = CH_NUM
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdi,
   output logic sdo
);
   // elaboration checks: the word layout and the frame sizes must agree
   if (CHANNELS != CH_NUM) begin : g_chk_channels
      $error("scr_readback_top: the readback layout serves exactly four channels");
   end
   if (FRAME_BITS != WORD_BITS + PAD_BITS) begin : g_chk_frame
      $error("scr_readback_top: the frame must hold the word and its padding");
   end
   if (FRAME_LEN != FRAME_BITS) begin : g_chk_len
      $error("scr_readback_top: the accepted frame length must match the shift register");
   end
   // a counter saturating at the frame length would accept overlong frames
   if (CNT_MAX <= FRAME_LEN) begin : g_chk_sat
      $error("scr_readback_top: the bit counter must saturate above the frame length");
   end

   // reset release and synchronised pins
   logic rst_meta_q;
   logic rst_n_q;
   logic [2:0] pins_s;
   logic sclk_s;
   logic sync_n_s;
   logic sdi_s;

   // framing and bit count
   logic sclk_prev_q;
   logic sync_prev_q;
   logic sclk_rise;
   logic frame_start;
   logic frame_end;
   logic [5:0] cnt_q;

   // command decode and readback load
   logic [FRAME_BITS-1:0] shift_q;
   logic frame_ok;
   logic is_read;
   logic [3:0] pmu_sel;
   logic [1:0] mode_sel;
   logic rd_sysctl;
   logic rd_other;
   logic wr_sysctl;
   logic wr_pmu;
   logic load_pend_q;
   logic load_zero_q;

   // control state written by the host
   logic [3:0] clamp_q;
   logic [3:0] cmp_out_q;
   logic cmp_global_q;
   logic gnd_sense_q;
   logic guard_route_q;
   logic clamp_route_q;
   logic link_res_q;
   logic guard_en_q;
   logic [1:0] range_q;
   logic therm_on_q;
   logic [1:0] therm_lim_q;
   logic latched_q;

   scr_state_if st ();

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'h0;
         rst_n_q <= 1'h0;
      end else begin
         rst_meta_q <= 1'h1;
         rst_n_q <= rst_meta_q;
      end
   end

   // serial pins come from the host's timing, so they are synchronised
   scr_pin_sync #(
      .WIDTH(3),
      .RESET_VAL(PIN_RST)
   ) u_pin_sync (
      .clock(clock),
      .rst_n(rst_n_q),
      .pin_async({sdi, sync_n, sclk}),
      .pin_sync(pins_s)
   );

   assign sclk_s = pins_s[0];
   assign sync_n_s = pins_s[1];
   assign sdi_s = pins_s[2];

   // serial clock history; resets to the idle low level so no false edge follows reset
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sclk_prev_q <= 1'h0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   // frame history; resets to the idle high level for the same reason
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sync_prev_q <= 1'h1;
      end else begin
         sync_prev_q <= sync_n_s;
      end
   end

   // only edges inside a frame count; the serial clock must stay
   // below a quarter of the system clock for the samples to see it
   assign sclk_rise = sclk_s & ~sclk_prev_q & ~sync_n_s;
   assign frame_start = sync_prev_q & ~sync_n_s;
   assign frame_end = ~sync_prev_q & sync_n_s;

   // bit counter saturates so overlong frames never wrap to a legal length
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cnt_q <= 6'h00;
      end else if (frame_start) begin
         cnt_q <= sclk_rise ? 6'h01 : 6'h00;
      end else if (sclk_rise && cnt_q != CNT_MAX) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // command decode of a completed frame; anything but a full 29-bit
   // frame changes nothing, so a 24-bit flush acts as a no-op
   assign frame_ok = frame_end && (cnt_q == FRAME_LEN); // RULE_17
   assign is_read = shift_q[CMD_RW_BIT];
   assign pmu_sel = shift_q[CMD_PMU_HI:CMD_PMU_LO];
   assign mode_sel = shift_q[CMD_MODE_HI:CMD_MODE_LO];

   // the readback command selects the word that the next frame shifts out
   assign rd_sysctl = frame_ok & is_read & (pmu_sel == PMU_NONE)
      & (mode_sel == MODE_SYSCTL); // RULE_15
   assign rd_other = frame_ok & is_read & ~rd_sysctl;
   assign wr_sysctl = frame_ok & ~is_read & (pmu_sel == PMU_NONE)
      & (mode_sel == MODE_SYSCTL);
   assign wr_pmu = frame_ok & ~is_read & (pmu_sel != PMU_NONE)
      & (mode_sel == MODE_SYSCTL);

   // freeze the image in the same cycle the command is accepted
   assign st.capture = rd_sysctl; // RULE_18

   // load request waits one cycle so the frozen image is settled
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         load_pend_q <= 1'h0;
         load_zero_q <= 1'h0;
      end else begin
         load_pend_q <= rd_sysctl | rd_other;
         load_zero_q <= rd_other;
      end
   end

   // one register both receives the command and returns the readback;
   // other registers' readback is outside this block and returns zero
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         shift_q <= RST_SHIFT;
      end else if (load_pend_q) begin
         shift_q <= load_zero_q ? RST_SHIFT : {st.word, PAD_FILL}; // RULE_16
      end else if (sclk_rise) begin
         shift_q <= {shift_q[FRAME_BITS-2:0], sdi_s};
      end
   end

   // data out is the top of the shift register, a flop output
   assign sdo = shift_q[FRAME_BITS-1];

   // per-channel enables: a later write from either path overwrites;
   // frames are serial, so two writes never land in one cycle
   genvar g;
   for (g = 0; g < CH_NUM; g++) begin : g_ch
      always_ff @(posedge clock or negedge rst_n_q) begin
         if (!rst_n_q) begin
            clamp_q[g] <= RST_CH_BITS[g];
         end else if (wr_sysctl) begin
            clamp_q[g] <= shift_q[W_CLAMP_LO+g]; // RULE_03
         end else if (wr_pmu && pmu_sel[g]) begin
            clamp_q[g] <= shift_q[PMU_CLAMP_BIT]; // RULE_03
         end
      end

      always_ff @(posedge clock or negedge rst_n_q) begin
         if (!rst_n_q) begin
            cmp_out_q[g] <= RST_CH_BITS[g];
         end else if (wr_sysctl) begin
            cmp_out_q[g] <= shift_q[W_CMPOUT_LO+g]; // RULE_05
         end else if (wr_pmu && pmu_sel[g]) begin
            cmp_out_q[g] <= shift_q[PMU_CMPOUT_BIT]; // RULE_05
         end
      end
   end

   // global comparator enable
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cmp_global_q <= RST_FLAG;
      end else if (wr_sysctl) begin
         cmp_global_q <= shift_q[W_CMP_GLOBAL]; // RULE_06
      end
   end

   // ground-sense mode: per channel or individual guard inputs
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         gnd_sense_q <= RST_FLAG;
      end else if (wr_sysctl) begin
         gnd_sense_q <= shift_q[W_GND_SENSE]; // RULE_07
      end
   end

   // fault routing to the combined fault pin
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         guard_route_q <= RST_FLAG;
         clamp_route_q <= RST_FLAG;
      end else if (wr_sysctl) begin
         guard_route_q <= shift_q[W_GUARD_ROUTE]; // RULE_08
         clamp_route_q <= shift_q[W_CLAMP_ROUTE]; // RULE_08
      end
   end

   // latched or unlatched fault outputs
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         latched_q <= RST_FLAG;
      end else if (wr_sysctl) begin
         latched_q <= shift_q[W_LATCHED]; // RULE_13
      end
   end

   // sense path: link resistors and guard amplifiers
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         link_res_q <= RST_FLAG;
         guard_en_q <= RST_FLAG;
      end else if (wr_sysctl) begin
         link_res_q <= shift_q[W_LINK_RES]; // RULE_09
         guard_en_q <= shift_q[W_GUARD_EN]; // RULE_10
      end
   end

   // measure output range code, kept exactly as written
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         range_q <= RST_FIELD2;
      end else if (wr_sysctl) begin
         range_q <= shift_q[W_RANGE_LO+1:W_RANGE_LO]; // RULE_11
      end
   end

   // thermal cutoff settings
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         therm_on_q <= RST_FLAG;
         therm_lim_q <= RST_FIELD2;
      end else if (wr_sysctl) begin
         therm_on_q <= shift_q[W_THERM_ON]; // RULE_12
         therm_lim_q <= shift_q[W_THERM_LIM_LO+1:W_THERM_LIM_LO]; // RULE_12
      end
   end

   // live control state handed to the word former
   assign st.clamp_on = clamp_q;
   assign st.cmp_out_on = cmp_out_q;
   assign st.comparator_global_on = cmp_global_q;
   assign st.per_channel_ground_sense = gnd_sense_q;
   assign st.guard_fault_route = guard_route_q;
   assign st.clamp_fault_route = clamp_route_q;
   assign st.internal_link_resistor = link_res_q;
   assign st.guard_amp_on = guard_en_q;
   assign st.meas_range = range_q;
   assign st.thermal_cutoff_on = therm_on_q;
   assign st.thermal_limit = therm_lim_q;
   assign st.fault_latched = latched_q;

   scr_word_form u_word_form (
      .clock(clock),
      .rst_n(rst_n_q),
      .st(st.former)
   );
endmodule

// ==== design/scr_pkg.sv ====
package scr_pkg;
   // serial frame geometry
   localparam int FRAME_BITS = 29;
   localparam int WORD_BITS = 24;
   localparam int PAD_BITS = 5;
   localparam int CH_NUM = 4;
   localparam int SYNC_STAGES = 2;
   localparam logic [5:0] FRAME_LEN = 6'h1D;
   localparam logic [5:0] CNT_MAX = 6'h3F;
   localparam logic [PAD_BITS-1:0] PAD_FILL = 5'h00;

   // command field positions inside a 29-bit frame
   localparam int CMD_RW_BIT = 28;
   localparam int CMD_PMU_HI = 27;
   localparam int CMD_PMU_LO = 24;
   localparam int CMD_MODE_HI = 23;
   localparam int CMD_MODE_LO = 22;
   localparam logic [1:0] MODE_SYSCTL = 2'h0;
   localparam logic [3:0] PMU_NONE = 4'h0;

   // readback word layout, also used as the system control write layout
   localparam int W_TYPE_HI = 23;
   localparam int W_TYPE_LO = 22;
   localparam int W_CLAMP_LO = 18;
   localparam int W_CMPOUT_LO = 14;
   localparam int W_CMP_GLOBAL = 13;
   localparam int W_GND_SENSE = 12;
   localparam int W_GUARD_ROUTE = 11;
   localparam int W_CLAMP_ROUTE = 10;
   localparam int W_LINK_RES = 9;
   localparam int W_GUARD_EN = 8;
   localparam int W_RANGE_LO = 6;
   localparam int W_THERM_ON = 5;
   localparam int W_THERM_LIM_LO = 3;
   localparam int W_LATCHED = 2;
   localparam int W_UNUSED_HI = 1;

   // per-channel register bits that share the clamp and comparator output enables
   localparam int PMU_CLAMP_BIT = 11;
   localparam int PMU_CMPOUT_BIT = 10;

   // reset values
   localparam logic [3:0] RST_CH_BITS = 4'h0;
   localparam logic [1:0] RST_FIELD2 = 2'h0;
   localparam logic RST_FLAG = 1'h0;
   localparam logic [23:0] RST_WORD = 24'h000000;
   localparam logic [28:0] RST_SHIFT = 29'h00000000;
   // synchroniser reset order {sdi, sync_n, sclk}: frame pin idles high
   localparam logic [2:0] PIN_RST = 3'h2;
endpackage

// ==== design/scr_state_if.sv ====
`timescale 1ns/10ps
interface scr_state_if;
   logic [3:0] clamp_on;
   logic [3:0] cmp_out_on;
   logic comparator_global_on;
   logic per_channel_ground_sense;
   logic guard_fault_route;
   logic clamp_fault_route;
   logic internal_link_resistor;
   logic guard_amp_on;
   logic [1:0] meas_range;
   logic thermal_cutoff_on;
   logic [1:0] thermal_limit;
   logic fault_latched;
   logic capture;
   logic [23:0] word;

   modport owner (
      output clamp_on, cmp_out_on, comparator_global_on, per_channel_ground_sense,
      output guard_fault_route, clamp_fault_route, internal_link_resistor, guard_amp_on,
      output meas_range, thermal_cutoff_on, thermal_limit, fault_latched, capture,
      input word
   );
   modport former (
      input clamp_on, cmp_out_on, comparator_global_on, per_channel_ground_sense,
      input guard_fault_route, clamp_fault_route, internal_link_resistor, guard_amp_on,
      input meas_range, thermal_cutoff_on, thermal_limit, fault_latched, capture,
      output word
   );
endinterface

// ==== design/scr_pin_sync.sv ====
`timescale 1ns/10ps
module scr_pin_sync
   import scr_pkg::*;
#(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync
);
   // refused at elaboration: a zero-width synchroniser has nothing to carry
   if (WIDTH < 1) begin : g_chk_width
      $error("scr_pin_sync: WIDTH must be at least 1");
   end

   // two flops per pin; the first is seen only by the second
   genvar g;
   for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            meta_q <= RESET_VAL[g];
            stable_q <= RESET_VAL[g];
         end else begin
            meta_q <= pin_async[g];
            stable_q <= meta_q;
         end
      end
      assign pin_sync[g] = stable_q;
   end
endmodule

// ==== design/scr_word_form.sv ====
`timescale 1ns/10ps
module scr_word_form
   import scr_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   scr_state_if.former st
);
   logic [WORD_BITS-1:0] word_d;
   logic [WORD_BITS-1:0] word_q;

   // assemble the live readback image from the control state
   always_comb begin
      word_d = RST_WORD;
      word_d[W_TYPE_HI:W_TYPE_LO] = 2'h0; // RULE_01
      word_d[W_CLAMP_LO+3:W_CLAMP_LO] = st.clamp_on; // RULE_02
      word_d[W_CMPOUT_LO+3:W_CMPOUT_LO] = st.cmp_out_on; // RULE_04
      word_d[W_CMP_GLOBAL] = st.comparator_global_on; // RULE_06
      word_d[W_GND_SENSE] = st.per_channel_ground_sense; // RULE_07
      word_d[W_GUARD_ROUTE] = st.guard_fault_route; // RULE_08
      word_d[W_CLAMP_ROUTE] = st.clamp_fault_route; // RULE_08
      word_d[W_LINK_RES] = st.internal_link_resistor; // RULE_09
      word_d[W_GUARD_EN] = st.guard_amp_on; // RULE_10
      word_d[W_RANGE_LO+1:W_RANGE_LO] = st.meas_range; // RULE_11
      word_d[W_THERM_ON] = st.thermal_cutoff_on; // RULE_12
      word_d[W_THERM_LIM_LO+1:W_THERM_LIM_LO] = st.thermal_limit; // RULE_12
      word_d[W_LATCHED] = st.fault_latched; // RULE_13
      word_d[W_UNUSED_HI:0] = 2'h0; // RULE_14
   end

   // snapshot at command completion so later writes cannot disturb it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         word_q <= RST_WORD;
      end else if (st.capture) begin
         word_q <= word_d; // RULE_18
      end
   end

   assign st.word = word_q;
endmodule

// ==== testbench/scr_readback_props.sv ====
`timescale 1ns/10ps
module scr_readback_props
   import scr_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdi,
   input wire logic sdo
);
   logic sclk_q, sync_q, rb_q, other_q;
   logic [5:0] cnt_q;
   logic [6:0] hdr_q;
   // pin-level edges; the design sees them two flops later, so sdo still shows the old bit
   wire logic rise = sclk && !sclk_q && !sync_n;
   wire logic fend = sync_n && !sync_q;

   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   // edge history of the host pins
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sclk_q <= 1'h0;
         sync_q <= 1'h1;
      end else begin
         sclk_q <= sclk;
         sync_q <= sync_n;
      end
   end

   // bit count and header of the frame, and what the last frame asked to load
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 6'h00;
         hdr_q <= 7'h00;
         rb_q <= 1'h0;
         other_q <= 1'h0;
      end else begin
         if (!sync_n && sync_q) cnt_q <= 6'h00;
         else if (rise && cnt_q != CNT_MAX) cnt_q <= cnt_q + 6'h01;
         if (rise && cnt_q < 6'h07) hdr_q <= {hdr_q[5:0], sdi};
         if (fend) begin
            rb_q <= (cnt_q == FRAME_LEN) && (hdr_q == 7'h40);
            other_q <= (cnt_q == FRAME_LEN) && hdr_q[6] && (hdr_q != 7'h40);
         end
      end
   end

   property p_rst_quiet;
      $rose(arst_n) |-> (!sdo) [*3];
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("sdo not low after reset");
   property p_type_zero;
      rb_q && rise && cnt_q < 6'h02 |-> !sdo;
   endproperty
   a_type_zero: assert property (p_type_zero) else $error("type bits not zero");
   property p_unused_zero;
      rb_q && rise && (cnt_q == 6'h16 || cnt_q == 6'h17) |-> !sdo;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");
   property p_pad_zero;
      rb_q && rise && cnt_q >= 6'h18 && cnt_q < FRAME_LEN |-> !sdo;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("pad bits not zero");
   property p_other_zero;
      other_q && rise |-> !sdo;
   endproperty
   a_other_zero: assert property (p_other_zero) else $error("other read not zero");
   property p_idle_hold;
      sync_n [*8] ##1 sync_n [*4] |-> $stable(sdo);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("sdo moved while idle");
   property p_low_hold;
      (!sync_n && !sclk) [*6] |-> $stable(sdo);
   endproperty
   a_low_hold: assert property (p_low_hold) else $error("sdo moved without clock");
   property p_shift_lag;
      rise |=> $stable(sdo);
   endproperty
   a_shift_lag: assert property (p_shift_lag) else $error("sdo moved too early");

   c_readback: cover property (fend && cnt_q == FRAME_LEN && hdr_q == 7'h40);
   c_flush: cover property (fend && cnt_q == 6'h18);
   c_slow: cover property ((!sync_n && !sclk) [*6]);
endmodule

bind scr_readback_top scr_readback_props u_props (
   .clock(clock),
   .arst_n(arst_n),
   .sclk(sclk),
   .sync_n(sync_n),
   .sdi(sdi),
   .sdo(sdo)
);

// ==== testbench/scr_host_model.sv ====
`timescale 1ns/10ps
module scr_host_model (
   input wire logic clock,
   input wire logic sdo,
   output logic sclk,
   output logic sync_n,
   output logic sdi
);
   // serial clock stands low and the frame idles high outside transfers
   initial begin
      sclk = 1'h0;
      sync_n = 1'h1;
      sdi = 1'h0;
   end

   // one frame, MSB first; half sets the speed in clock cycles per sclk phase
   task automatic xfer(input logic [28:0] tx, input int nbits, input int half,
                       output logic [28:0] rx);
      int i;
      rx = 29'h00000000;
      @(posedge clock);
      sync_n <= 1'h0;
      for (i = nbits - 1; i >= 0; i--) begin
         sdi <= tx[i];
         repeat (half) @(posedge clock);
         rx[i] = sdo; // bit shown before the shifting edge
         sclk <= 1'h1;
         repeat (half) @(posedge clock);
         sclk <= 1'h0;
      end
      repeat (half) @(posedge clock);
      sync_n <= 1'h1;
      sdi <= ~tx[0]; // released line must not keep its last value
      repeat (14) @(posedge clock); // long gap so a readback load lands before the next frame
   endtask
endmodule

// ==== testbench/test_system_control_readback_word.sv ====
`timescale 1ns/10ps
module test_system_control_readback_word
   import scr_pkg::*;
;
   logic clock = 1'h0;
   logic arst_n = 1'h0;
   logic sclk, sync_n, sdi, sdo;
   logic [23:0] exp_w;
   logic [28:0] rx;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #10 clock = ~clock;

   scr_readback_top dut (.clock(clock), .arst_n(arst_n), .sclk(sclk), .sync_n(sync_n),
                         .sdi(sdi), .sdo(sdo));
   scr_host_model host (.clock(clock), .sdo(sdo), .sclk(sclk), .sync_n(sync_n), .sdi(sdi));

   task automatic chk(input string what, input logic [28:0] want, input logic [28:0] got);
      cmp_count++;
      if (got !== want) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, want, got);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // system control write; its data layout matches the readback word
   task automatic wr_sys(input logic [21:0] d);
      host.xfer({1'h0, PMU_NONE, MODE_SYSCTL, d}, 29, 3, rx);
      exp_w[21:2] = d[21:2];
   endtask

   // per-channel write touching only clamp and comparator output enables
   task automatic wr_ch(input logic [3:0] m, input logic c, input logic o);
      int i;
      host.xfer({1'h0, m, MODE_SYSCTL, 10'h000, c, o, 10'h000}, 29, 3, rx);
      for (i = 0; i < 4; i++) if (m[i]) begin
         exp_w[18 + i] = c;
         exp_w[14 + i] = o;
      end
   endtask

   // readback command, then a no-op 24-bit frame to shift the word out
   task automatic rd_chk(input string what, input logic [3:0] sel, input int half,
                         input logic [23:0] want);
      host.xfer({1'h1, sel, MODE_SYSCTL, 22'h000000}, 29, half, rx);
      host.xfer(29'h00FFFFFF, 24, half, rx);
      chk(what, {5'h00, want}, {5'h00, rx[23:0]});
   endtask

   // hang guard, far above the roughly 16000 cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         $display("[ERR] run length expected below 60000 seen %0d", cycles);
         complete_run();
      end
   end

   initial begin
      int i;
      logic [23:0] old;
      exp_w = 24'h000000;
      repeat (12) @(posedge clock);
      arst_n <= 1'h1;
      repeat (8) @(posedge clock);
      rd_chk("reset word", PMU_NONE, 3, exp_w);
      $display("test reset done");
      for (i = 2; i < 22; i++) begin
         wr_sys(22'h000001 << i);
         rd_chk("single field bit", PMU_NONE, 3, exp_w);
      end
      wr_sys(22'h3FFFFF);
      rd_chk("all fields set", PMU_NONE, 3, exp_w);
      $display("test fields done");
      wr_ch(4'h5, 1'h0, 1'h0);
      rd_chk("channel write clears", PMU_NONE, 3, exp_w);
      wr_ch(4'h8, 1'h0, 1'h1);
      rd_chk("channel write mixed", PMU_NONE, 3, exp_w);
      wr_sys(22'h0C0000);
      rd_chk("system write after channel", PMU_NONE, 3, exp_w);
      $display("test latest write done");
      // a write frame after readback shifts the snapshot out, padded below
      old = exp_w;
      host.xfer({1'h1, PMU_NONE, MODE_SYSCTL, 22'h000000}, 29, 7, rx);
      wr_sys(22'h15555C);
      chk("snapshot shifted", {old, PAD_FILL}, rx);
      rd_chk("word after snapshot", PMU_NONE, 7, exp_w);
      $display("test snapshot done");
      // frames of the wrong length and writes of another mode change nothing
      host.xfer(29'h00000000, 28, 3, rx);
      host.xfer(29'h00000000, 24, 3, rx);
      host.xfer({1'h0, PMU_NONE, 2'h1, 22'h000000}, 29, 3, rx);
      rd_chk("after refused frames", PMU_NONE, 3, exp_w);
      rd_chk("other register read", 4'h1, 3, 24'h000000);
      $display("test refused done");
      complete_run();
   end
endmodule
